//--- qbr_pkg.sv
// Shared constants and types for the busy, reset and fast-clear link
// Summary of operation
// R01 - Busy on convert, analog reset, full, memtest
// R02 - Busy drives pin, LED, status bits
// R03 - Busy rises after gate, falls at end
// R04 - Gate pulses ignored while busy
// R05 - Wired OR/NAND busy; report OR line
// R06 - Strap selects stop on any/own busy
// R07 - Data reset clears data, keeps registers
// R08 - Clear-data bit holds data reset until cleared
// R09 - Panel reset: data or software by scope
// R10 - Software reset adds register defaults
// R11 - Software-reset bit holds reset until cleared
// R12 - Single-shot write resets during the access
// R13 - Hardware reset at power-up and system reset
// R14 - Host reinitialises device after any reset; host flags only its own reset and panel and system resets, not software resets
// R15 - Fast clear inside window aborts conversion
// R16 - Fast-clear pulse meets minimum width
// R17 - Gates refused 600 ns after fast clear
// R18 - Event presence pin, status, OR line bit
// R19 - Veto inhibits conversion
// R20 - Panel reset clears integrators, stops conversion
// R21 - Busy LED lit while configuring
// R22 - Gate accepted only without veto, clear, busy
// R23 - Fast clear outside window has no effect
package qbr_pkg;
    localparam int CLK_NS = 20;
    localparam int FAST_ABORT_INPUT_MIN_NS = 30;
    localparam int FAST_ABORT_INPUT_MIN_CYC = (FAST_ABORT_INPUT_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int FAST_ABORT_INPUT_REC_NS = 600;
    localparam int FAST_ABORT_INPUT_REC_CYC = (FAST_ABORT_INPUT_REC_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_NS = 6000;
    localparam int CONV_CYC = CONV_NS / CLK_NS;
    localparam int CFG_NS = 2000;
    localparam int CFG_CYC = CFG_NS / CLK_NS;
    localparam int EVT_DEPTH = 32;
    // Device register indices on the link
    localparam logic [3:0] RI_STATUS1 = 4'h0;
    localparam logic [3:0] RI_CONTROL1 = 4'h1;
    localparam logic [3:0] RI_BSET1 = 4'h2;
    localparam logic [3:0] RI_BCLR1 = 4'h3;
    localparam logic [3:0] RI_BSET2 = 4'h4;
    localparam logic [3:0] RI_BCLR2 = 4'h5;
    localparam logic [3:0] RI_SSRESET = 4'h6;
    localparam logic [3:0] RI_FCWIN = 4'h7;
    localparam logic [3:0] RI_EVINC = 4'h8;
    localparam logic [3:0] RI_EVCNT = 4'h9;
    // Device field positions
    localparam int ST_EVT = 0;
    localparam int ST_EVT_OR = 1;
    localparam int ST_BUSY = 2;
    localparam int ST_GBUSY = 3;
    localparam int C1_SCOPE = 4;
    localparam int B1_SWRST = 7;
    localparam int B2_MEMTEST = 0;
    localparam int B2_CLRDATA = 2;
    localparam logic [15:0] CONTROL1_RST = 16'h0000;
    localparam logic [15:0] BSET2_RST = 16'h0000;
    localparam logic [15:0] FCWIN_RST = 16'h0032;
    // Host register byte offsets
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_CTRL = 8'h04;
    localparam logic [7:0] A_ACC = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0c;
    localparam int CMD_GATE = 0;
    localparam int CMD_FAST_ABORT_INPUT = 1;
    localparam int CMD_PRST = 2;
    localparam int CMD_SYSRST = 3;
    localparam int CT_VETO = 0;
    localparam int CT_PBUSY = 1;
    localparam int CT_PEVT = 2;
    localparam int CT_GW_LSB = 8;
    localparam int ACC_ADDR_LSB = 16;
    localparam int ACC_WR = 20;
    localparam int HS_PEND = 0;
    localparam int HS_BUSY_OR = 1;
    localparam int HS_EVT_OR = 2;
    localparam int HS_UNINIT = 3;
    localparam int HS_RD_LSB = 16;
    localparam logic [31:0] CTRL_RST = 32'h0000_0400;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_INTEG = 4'h2,
        S_CONV = 4'h4,
        S_CLEAR = 4'h8
    } qbr_state_e;
endpackage

//--- qbr_link_if.sv
`timescale 1ns/100ps
// Link between the board and its controller, with wired bus resolution
interface qbr_link_if;
    logic gate;
    logic veto;
    logic fast_abort_input;
    logic panel_reset;
    logic sys_reset;
    logic busy_o;
    logic busy_oe;
    logic event_present_line;
    logic event_oe;
    logic peer_busy;
    logic peer_event;
    logic busy_or_line;
    logic busy_nand_line;
    logic event_present_or_line;
    logic event_present_nand_line;
    logic acc_req;
    logic acc_wr;
    logic [3:0] acc_addr;
    logic [15:0] acc_wdata;
    logic [15:0] acc_rdata;
    logic acc_ack;
    // Wired OR of every driver plus its complement line
    assign busy_or_line = (busy_oe & busy_o) | peer_busy; // R05
    assign busy_nand_line = ~busy_or_line; // R05
    assign event_present_or_line = (event_oe & event_present_line) | peer_event;
    assign event_present_nand_line = ~event_present_or_line;
    modport dev(
        input gate, veto, fast_abort_input, panel_reset, sys_reset,
        input busy_or_line, event_present_or_line,
        input acc_req, acc_wr, acc_addr, acc_wdata,
        output busy_o, busy_oe, event_present_line, event_oe,
        output acc_rdata, acc_ack
    );
    modport host(
        output gate, veto, fast_abort_input, panel_reset, sys_reset,
        output peer_busy, peer_event,
        output acc_req, acc_wr, acc_addr, acc_wdata,
        input busy_or_line, busy_nand_line, event_present_or_line,
        input event_present_nand_line, acc_rdata, acc_ack
    );
endinterface

//--- qbr_dev.sv
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
// Board end: busy generation, reset levels and fast-clear window
module qbr_dev
    import qbr_pkg::*;
#(
    parameter int DEPTH = EVT_DEPTH,
    parameter int CONV_CYCLES = CONV_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    qbr_link_if.dev link,
    input wire logic busy_mode_strap,
    output logic busy_led,
    output logic event_led,
    output logic integ_clear,
    output logic conv_active
);
    localparam int NS = 8;
    localparam int CW = $clog2(DEPTH + 1);

    function automatic logic sel(input logic [3:0] a, input logic [3:0] idx);
        sel = (a == idx);
    endfunction

    logic [NS-1:0] pin_raw;
    logic [NS-1:0] meta_ff;
    logic [NS-1:0] sync_ff;
    logic [NS-1:0] prev_ff;
    logic strap_ff;
    logic [15:0] ctrl1_ff, bset2_ff, fcwin_ff, evcnt_ff;
    logic swrst_ff;
    logic [CW-1:0] evnum_ff;
    qbr_state_e state_ff, nxt_state;
    logic [15:0] tmr_ff, nxt_tmr, win_ff, nxt_win;
    logic [7:0] cfg_ff;
    logic ack_ff, busy_ff, evt_ff, intclr_ff, conv_ff;
    logic [15:0] rdata_ff, rd_mux;
    logic conv_done;

    // Pins cross two flops before use
    assign pin_raw = {busy_mode_strap, link.event_present_or_line,
                      link.busy_or_line, link.sys_reset, link.panel_reset,
                      link.fast_abort_input, link.veto, link.gate};
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_sync
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    meta_ff[gi] <= 1'b0;
                    sync_ff[gi] <= 1'b0;
                    prev_ff[gi] <= 1'b0;
                end else begin
                    meta_ff[gi] <= pin_raw[gi];
                    sync_ff[gi] <= meta_ff[gi];
                    prev_ff[gi] <= sync_ff[gi];
                end
            end
        end
    endgenerate

    wire gate_s = sync_ff[0];
    wire veto_s = sync_ff[1];
    wire fast_abort_input_s = sync_ff[2];
    wire sysrst_s = sync_ff[4];
    wire gbusy_s = sync_ff[5];
    wire evtor_s = sync_ff[6];
    wire gate_rise = sync_ff[0] & ~prev_ff[0];
    wire fast_abort_input_rise = sync_ff[2] & ~prev_ff[2];
    wire prst_rise = sync_ff[3] & ~prev_ff[3];

    // Access decode; ack the cycle after the take
    wire take = link.acc_req & ~ack_ff;
    wire wr_take = take & link.acc_wr;
    wire wr_c1 = wr_take & sel(link.acc_addr, RI_CONTROL1);
    wire wr_bs1 = wr_take & sel(link.acc_addr, RI_BSET1);
    wire wr_bc1 = wr_take & sel(link.acc_addr, RI_BCLR1);
    wire wr_bs2 = wr_take & sel(link.acc_addr, RI_BSET2);
    wire wr_bc2 = wr_take & sel(link.acc_addr, RI_BCLR2);
    wire wr_fcw = wr_take & sel(link.acc_addr, RI_FCWIN);
    wire wr_inc = wr_take & sel(link.acc_addr, RI_EVINC);
    // Held for the whole write, not only the taken cycle
    wire ssr_act = link.acc_req & link.acc_wr
                   & sel(link.acc_addr, RI_SSRESET); // R12

    // Reset hierarchy: hardware > software > data
    wire hard_rst = reset | sysrst_s; // R13
    wire soft_rst = hard_rst | swrst_ff | ssr_act
                    | (prst_rise & ctrl1_ff[C1_SCOPE]); // R09
    wire data_rst = soft_rst | bset2_ff[B2_CLRDATA] | prst_rise; // R07 R20

    // Busy conditions and acquisition stop
    wire full = (evnum_ff == CW'(DEPTH));
    wire busy_own = (state_ff != S_IDLE) | data_rst | full
                    | bset2_ff[B2_MEMTEST]; // R01
    wire stop = strap_ff ? (busy_own | gbusy_s) : busy_own; // R06
    wire accept = gate_rise & ~veto_s & ~fast_abort_input_s & ~stop; // R04 R22
    wire in_win = ((state_ff == S_INTEG) | (state_ff == S_CONV))
                  & (win_ff < fcwin_ff);
    wire abort = fast_abort_input_rise & in_win; // R15 R23
    wire store = conv_done & ~full;
    wire unload = wr_inc & (evnum_ff != '0);

    // Strap followed while configuring, so the synchroniser has settled
    always_ff @(posedge core_clk) begin
        if (reset)
            strap_ff <= 1'b0;
        else if (cfg_ff != 8'h00)
            strap_ff <= sync_ff[7]; // R06
    end

    // Software-reset registers; hold bit only by hardware
    always_ff @(posedge core_clk) begin
        if (soft_rst) begin
            ctrl1_ff <= CONTROL1_RST; // R10
            bset2_ff <= BSET2_RST;
            fcwin_ff <= FCWIN_RST;
        end else begin
            if (wr_c1)
                ctrl1_ff <= link.acc_wdata;
            if (wr_bs2)
                bset2_ff <= bset2_ff | link.acc_wdata; // R08
            else if (wr_bc2)
                bset2_ff <= bset2_ff & ~link.acc_wdata; // R08
            if (wr_fcw)
                fcwin_ff <= link.acc_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (hard_rst)
            swrst_ff <= 1'b0;
        else if (wr_bs1 && link.acc_wdata[B1_SWRST])
            swrst_ff <= 1'b1; // R11
        else if (wr_bc1 && link.acc_wdata[B1_SWRST])
            swrst_ff <= 1'b0; // R11
    end

    // Conversion sequence with fast-clear recovery
    always_comb begin
        nxt_state = state_ff;
        nxt_tmr = tmr_ff;
        nxt_win = (win_ff == 16'hffff) ? win_ff : win_ff + 16'h0001;
        conv_done = 1'b0;
        case (state_ff)
            S_IDLE: begin
                if (accept) begin
                    nxt_state = S_INTEG; // R03
                    nxt_win = 16'h0000;
                end
            end
            S_INTEG: begin
                if (abort) begin
                    nxt_state = S_CLEAR; // R17
                    nxt_tmr = 16'(FAST_ABORT_INPUT_REC_CYC - 1);
                end else if (veto_s) begin
                    nxt_state = S_IDLE; // R19
                end else if (!gate_s) begin
                    nxt_state = S_CONV;
                    nxt_tmr = 16'(CONV_CYCLES - 1);
                end
            end
            S_CONV: begin
                if (abort) begin
                    nxt_state = S_CLEAR; // R15
                    nxt_tmr = 16'(FAST_ABORT_INPUT_REC_CYC - 1);
                end else if (veto_s) begin
                    nxt_state = S_IDLE; // R19
                end else if (tmr_ff == 16'h0000) begin
                    nxt_state = S_IDLE; // R03
                    conv_done = 1'b1;
                end else begin
                    nxt_tmr = tmr_ff - 16'h0001;
                end
            end
            S_CLEAR: begin
                if (tmr_ff == 16'h0000)
                    nxt_state = S_IDLE; // R17
                else
                    nxt_tmr = tmr_ff - 16'h0001;
            end
            default: nxt_state = S_IDLE;
        endcase
    end

    // Data reset stops conversion and empties the event store
    always_ff @(posedge core_clk) begin
        if (data_rst) begin
            state_ff <= S_IDLE; // R20
            tmr_ff <= 16'h0000;
            win_ff <= 16'h0000;
            evnum_ff <= '0; // R07
            evcnt_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            tmr_ff <= nxt_tmr;
            win_ff <= nxt_win;
            if (store && !unload)
                evnum_ff <= evnum_ff + CW'(1);
            else if (unload && !store)
                evnum_ff <= evnum_ff - CW'(1);
            if (accept)
                evcnt_ff <= evcnt_ff + 16'h0001;
        end
    end

    // Configuration phase after power-up lights the busy LED
    always_ff @(posedge core_clk) begin
        if (reset)
            cfg_ff <= 8'(CFG_CYC);
        else if (cfg_ff != 8'h00)
            cfg_ff <= cfg_ff - 8'h01;
    end

    // Register read selection
    always_comb begin
        case (link.acc_addr)
            RI_STATUS1: rd_mux = {12'h000, gbusy_s, busy_ff,
                                  evtor_s, evt_ff}; // R02 R05 R18
            RI_CONTROL1: rd_mux = ctrl1_ff;
            RI_BSET1, RI_BCLR1: rd_mux = 16'(swrst_ff) << B1_SWRST;
            RI_BSET2, RI_BCLR2: rd_mux = bset2_ff;
            RI_FCWIN: rd_mux = fcwin_ff;
            RI_EVCNT: rd_mux = evcnt_ff;
            default: rd_mux = 16'h0000;
        endcase
    end

    // Pin and indicator flops; the pin outputs are registered
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ack_ff <= 1'b0;
            rdata_ff <= 16'h0000;
            busy_ff <= 1'b0;
            evt_ff <= 1'b0;
            intclr_ff <= 1'b0;
            conv_ff <= 1'b0;
        end else begin
            ack_ff <= take;
            if (take && !link.acc_wr)
                rdata_ff <= rd_mux;
            busy_ff <= busy_own; // R02
            evt_ff <= (evnum_ff != '0); // R18
            intclr_ff <= data_rst | abort; // R15 R20
            conv_ff <= (state_ff == S_CONV);
        end
    end

    assign link.busy_o = busy_ff; // R02
    assign link.busy_oe = busy_ff; // R05
    assign link.event_present_line = evt_ff; // R18
    assign link.event_oe = evt_ff;
    assign link.acc_ack = ack_ff;
    assign link.acc_rdata = rdata_ff;
    assign busy_led = busy_ff | (cfg_ff != 8'h00); // R02 R21
    assign event_led = evt_ff;
    assign integ_clear = intclr_ff;
    assign conv_active = conv_ff;
endmodule // qbr_dev

//--- qbr_host.sv
`timescale 1ns/100ps
// Controller end: AXI4-Lite registers driving the board link
module qbr_host
    import qbr_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    qbr_link_if.host link,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic have_aw_ff, have_w_ff, bvalid_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff, ctrl_ff;
    logic [7:0] pcnt_ff [4];
    logic [3:0] pulse_ff;
    logic [4:0] fhold_ff;
    logic req_ff, accwr_ff, uninit_ff;
    logic [3:0] accaddr_ff;
    logic [15:0] accdata_ff, last_rd_ff;

    // Write address and data are taken in either order
    assign s_axi_awready = ~have_aw_ff & ~bvalid_ff;
    assign s_axi_wready = ~have_w_ff & ~bvalid_ff;
    wire wr_go = have_aw_ff & have_w_ff & ~bvalid_ff;
    wire [31:0] wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                         {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    wire [31:0] wval = wdata_ff & wmask;
    wire hit_cmd = wr_go & (awaddr_ff == A_CMD);
    wire hit_ctrl = wr_go & (awaddr_ff == A_CTRL);
    wire hit_acc = wr_go & (awaddr_ff == A_ACC) & ~req_ff;
    wire wr_ok = (awaddr_ff == A_CMD) | (awaddr_ff == A_CTRL)
                 | (awaddr_ff == A_ACC);
    wire rd_ok = (s_axi_araddr[7:4] == 4'h0) & (s_axi_araddr[1:0] == 2'h0);
    // Gate command refused during fast-clear recovery
    wire gate_ok = (fhold_ff == 5'h00); // R17
    wire [3:0] fire = hit_cmd ? {wval[CMD_SYSRST], wval[CMD_PRST],
                      wval[CMD_FAST_ABORT_INPUT], wval[CMD_GATE] & gate_ok} : 4'h0;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            have_aw_ff <= 1'b0;
            have_w_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                have_aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                have_w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                have_aw_ff <= 1'b0;
                have_w_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Read channel answers one cycle after the address is taken
    assign s_axi_arready = ~rvalid_ff;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                A_CTRL: rdata_ff <= ctrl_ff;
                A_ACC: rdata_ff <= {11'h000, accwr_ff, accaddr_ff,
                                    accdata_ff};
                A_STAT: rdata_ff <= {last_rd_ff, 12'h000, uninit_ff,
                                     link.event_present_or_line,
                                     link.busy_or_line, req_ff};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset)
            ctrl_ff <= CTRL_RST;
        else if (hit_ctrl)
            ctrl_ff <= (ctrl_ff & ~wmask) | wval;
    end

    // Pulses: gate width from control, others min width
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pulse
            wire [7:0] load = (gi == CMD_GATE)
                ? ctrl_ff[CT_GW_LSB +: 8] : 8'(FAST_ABORT_INPUT_MIN_CYC); // R16
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    pcnt_ff[gi] <= 8'h00;
                    pulse_ff[gi] <= 1'b0;
                end else if (fire[gi] && pcnt_ff[gi] == 8'h00) begin
                    pcnt_ff[gi] <= load;
                    pulse_ff[gi] <= (load != 8'h00);
                end else if (pcnt_ff[gi] != 8'h00) begin
                    pcnt_ff[gi] <= pcnt_ff[gi] - 8'h01;
                    pulse_ff[gi] <= (pcnt_ff[gi] != 8'h01);
                end
            end
        end
    endgenerate

    // Recovery timer starts at the fast-clear leading edge
    always_ff @(posedge core_clk) begin
        if (reset)
            fhold_ff <= 5'h00;
        else if (fire[CMD_FAST_ABORT_INPUT])
            fhold_ff <= 5'(FAST_ABORT_INPUT_REC_CYC); // R17
        else if (fhold_ff != 5'h00)
            fhold_ff <= fhold_ff - 5'h01;
    end

    // Link access; request held until the board acks
    always_ff @(posedge core_clk) begin
        if (reset) begin
            req_ff <= 1'b0;
            accwr_ff <= 1'b0;
            accaddr_ff <= 4'h0;
            accdata_ff <= 16'h0000;
            last_rd_ff <= 16'h0000;
        end else if (hit_acc) begin
            req_ff <= 1'b1; // R08 R11 R12
            accwr_ff <= wval[ACC_WR];
            accaddr_ff <= wval[ACC_ADDR_LSB +: 4];
            accdata_ff <= wval[15:0];
        end else if (req_ff && link.acc_ack) begin
            req_ff <= 1'b0;
            if (!accwr_ff)
                last_rd_ff <= link.acc_rdata;
        end
    end

    // Board needs its configuration written again
    always_ff @(posedge core_clk) begin
        if (reset)
            uninit_ff <= 1'b1; // R14
        else if (fire[CMD_SYSRST] || fire[CMD_PRST])
            uninit_ff <= 1'b1; // R14
        else if (hit_acc && wval[ACC_WR])
            uninit_ff <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign link.gate = pulse_ff[CMD_GATE];
    assign link.fast_abort_input = pulse_ff[CMD_FAST_ABORT_INPUT]; // R16
    assign link.panel_reset = pulse_ff[CMD_PRST];
    assign link.sys_reset = pulse_ff[CMD_SYSRST];
    assign link.veto = ctrl_ff[CT_VETO];
    assign link.peer_busy = ctrl_ff[CT_PBUSY];
    assign link.peer_event = ctrl_ff[CT_PEVT];
    assign link.acc_req = req_ff;
    assign link.acc_wr = accwr_ff;
    assign link.acc_addr = accaddr_ff;
    assign link.acc_wdata = accdata_ff;
endmodule // qbr_host

//--- qbr_link_monitor.sv
// Assertions on the link joining the board and controller ends
`timescale 1ns/100ps
module qbr_link_monitor (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic gate,
    input wire logic veto,
    input wire logic fast_abort_input,
    input wire logic panel_reset,
    input wire logic sys_reset,
    input wire logic busy_o,
    input wire logic busy_oe,
    input wire logic busy_or_line,
    input wire logic event_present_line,
    input wire logic acc_req,
    input wire logic acc_ack
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // Busy timing; veto may end conversion early
    busy_drive_a: assert property (busy_o |-> busy_oe)
        else $error("busy driven without enable");
    gate_busy_a: assert property ($rose(gate) && !busy_or_line
        && !veto |-> ##[2:8] busy_o)
        else $error("accepted gate did not raise busy");
    conv_hold_a: assert property ($rose(busy_o) && !veto
        && $past(gate, 3) |=> busy_o [*8])
        else $error("busy dropped too early");
    // Register access handshake on the link
    ack_take_a: assert property ($rose(acc_req) |=> acc_ack)
        else $error("access not answered in one cycle");
    ack_pulse_a: assert property (acc_ack |=> !acc_ack && !acc_req)
        else $error("access answer not a single pulse");
    // Pulses and the resets they cause
    fast_abort_input_width_a: assert property ($rose(fast_abort_input)
        |=> fast_abort_input ##1 !fast_abort_input)
        else $error("fast clear pulse width wrong");
    prst_clear_a: assert property ($rose(panel_reset)
        |-> ##[1:8] !event_present_line && !busy_o)
        else $error("panel reset left data or busy");
    sysrst_clear_a: assert property ($rose(sys_reset)
        |-> ##[2:8] !event_present_line && !busy_o)
        else $error("system reset left data or busy");
    cover property ($rose(busy_o));
    cover property ($rose(fast_abort_input) && busy_o);
    cover property ($rose(panel_reset));
endmodule // qbr_link_monitor

//--- tb_top.sv
// Bench driving the controller over AXI4-Lite with the board attached
`timescale 1ns/100ps
module tb_top;
    import qbr_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int num_errors = 0, comparisons = 0;
    qbr_link_if link();
    qbr_host u_qbr_host(.*);
    // Short conversion
    qbr_dev #(.CONV_CYCLES(40)) u_qbr_dev(.core_clk, .reset, .link,
        .busy_mode_strap(1'b1), .busy_led(), .event_led(),
        .integ_clear(), .conv_active());
    qbr_link_monitor u_qbr_link_monitor(.core_clk, .reset,
        .gate(link.gate), .veto(link.veto),
        .fast_abort_input(link.fast_abort_input),
        .panel_reset(link.panel_reset), .sys_reset(link.sys_reset),
        .busy_o(link.busy_o), .busy_oe(link.busy_oe),
        .busy_or_line(link.busy_or_line),
        .event_present_line(link.event_present_line),
        .acc_req(link.acc_req), .acc_ack(link.acc_ack));
    initial forever #10 core_clk = ~core_clk;
    // Handshakes sampled at rising edges
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        {q, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // Link access done within three cycles
    task automatic dev(logic w, logic [3:0] i, logic [15:0] d);
        wr(A_ACC, {11'h0, w, i, d});
        repeat (8) @(posedge core_clk);
    endtask
    task automatic dchk(string n, logic [3:0] i, logic [15:0] e);
        dev(1'b0, i, 16'h0);
        rd(A_STAT);
        chk(n, {16'h0, e}, {16'h0, q[31:16]});
    endtask
    task automatic cmd(input logic [3:0] b, input int n);
        wr(A_CMD, {28'h0, b});
        repeat (n) @(posedge core_clk);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge core_clk);
        num_errors++;
        results();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        repeat (120) @(posedge core_clk);
        rd(A_CTRL);
        chk("ctrl", CTRL_RST, q);
        rd(8'h10);
        chk("resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        cmd(4'h1, 12);
        cmd(4'h1, 100);
        dchk("status", RI_STATUS1, 16'h0003);
        dchk("count", RI_EVCNT, 16'h0001);
        dev(1'b1, RI_BSET2, 16'h0001);
        dchk("status", RI_STATUS1, 16'h000f);
        dev(1'b1, RI_BCLR2, 16'h0001);
        wr(A_CTRL, CTRL_RST | 32'h2);
        cmd(4'h1, 100);
        dchk("status", RI_STATUS1, 16'h000b);
        dchk("count", RI_EVCNT, 16'h0001);
        wr(A_CTRL, CTRL_RST);
        $display("test busy done");
        cmd(4'h1, 2);
        cmd(4'h2, 100);
        dev(1'b1, RI_EVINC, 16'h0);
        dchk("status", RI_STATUS1, 16'h0000);
        dev(1'b1, RI_FCWIN, 16'h0001);
        cmd(4'h1, 20);
        cmd(4'h2, 100);
        dchk("status", RI_STATUS1, 16'h0003);
        $display("test fast clear done");
        cmd(4'h4, 20);
        dchk("status", RI_STATUS1, 16'h0000);
        dchk("count", RI_EVCNT, 16'h0000);
        dchk("window", RI_FCWIN, 16'h0001);
        dev(1'b1, RI_CONTROL1, 16'h0010);
        cmd(4'h4, 20);
        dchk("window", RI_FCWIN, FCWIN_RST);
        dchk("control", RI_CONTROL1, CONTROL1_RST);
        dev(1'b1, RI_FCWIN, 16'h0005);
        dev(1'b1, RI_SSRESET, 16'h0);
        dchk("window", RI_FCWIN, FCWIN_RST);
        dev(1'b1, RI_BSET1, 16'h0080);
        dchk("hold", RI_BSET1, 16'h0080);
        cmd(4'h8, 20);
        dchk("hold", RI_BSET1, 16'h0000);
        $display("test resets done");
        results();
    end
endmodule // tb_top
